// file: include/bdar_pkg.sv
/*
  Shared constants and types for the button debounce and auto-repeat engine.
  Assumes a single 100 MHz clock domain and a plain register-port master.
*/
`default_nettype none
package bdar_pkg;
  // Register indices, word addressed
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_DELAY  = 4'h1;
  localparam logic [3:0] ADDR_RATE   = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_WORK   = 4'h4;
  localparam logic [3:0] ADDR_INVOKE = 4'h5;
  // Control field positions
  localparam int CTRL_PIN_LSB    = 0;
  localparam int CTRL_PIN_MSB    = 3;
  localparam int CTRL_PRESSED    = 4;
  localparam int CTRL_TARGET     = 5;
  localparam int CTRL_NARROW     = 6;
  // Status field positions
  localparam int STAT_BRANCH     = 0;
  localparam int STAT_DONE       = 1;
  localparam int STAT_MATCH      = 2;
  // Reset values
  localparam logic [6:0] CTRL_RST  = 7'h00;
  localparam logic [7:0] DELAY_RST = 8'h00;
  localparam logic [7:0] RATE_RST  = 8'h00;
  localparam logic [7:0] WORK_RST  = 8'h00;
  // Special delay settings, pin count and narrow-mode index limit
  localparam logic [7:0] DELAY_RAW     = 8'h00;
  localparam logic [7:0] DELAY_NOREPT  = 8'hff;
  localparam int         PIN_COUNT     = 16;
  localparam logic [3:0] NARROW_MAX    = 4'h7;
endpackage
`default_nettype wire

// file: include/bdar_sync_if.sv
/*
  Interface between the top and its pin synchroniser.
  Assumes both ends run on the same clock.
*/
`default_nettype none
interface bdar_sync_if;
  logic [15:0] pinSync;
  modport owner (input pinSync);
  modport sync  (output pinSync);
endinterface
`default_nettype wire

// file: rtl/bdar_pin_sync.sv
/*
  Two-stage synchroniser for the sixteen button pins.
  Assumes pins are asynchronous to ref_clk.
*/
`default_nettype none
module bdar_pin_sync
  import bdar_pkg::*;
(
  input  wire logic        ref_clk, // System clock
  input  wire logic        rstn,    // Async reset, active low
  input  wire logic [15:0] pinIn,   // Raw pin levels
  bdar_sync_if.sync        sif      // Synchronised levels
);
  typedef struct packed {
    logic [15:0] stage1;
    logic [15:0] stage2;
  } bdar_sync_s;
  bdar_sync_s st;
  bdar_sync_s next_st;

  // First stage feeds only the second stage
  always_comb begin
    next_st.stage1 = pinIn;
    next_st.stage2 = st.stage1;
  end

  // State register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sif.pinSync = st.stage2;
endmodule
`default_nettype wire

// file: rtl/bdar_button.sv
/*
  Button debounce and auto-repeat engine. Software writes pin, levels,
  delay and rate, then writes the invoke register once per loop pass;
  each write is one routine cycle and the branch decision is in status.
  Assumes a register master as described in the hand-over and async pins.
*/
// Function
// - Sixteen-line pin select, forced to input
// - Narrow mode limits index to 0-7
// - Pressed level chooses active high or low
// - Delay counts cycles before auto-repeat
// - Delay zero acts on raw level
// - Delay 255 debounces, never repeats
// - Rate counts cycles between repeats
// - One-byte workspace, zero before use
// - Reset clears all state to zero
// - Target state picks branch polarity
// - One sample and one step per call
// - First match starts count and acts
// - Count reaching delay acts again
// - Then act every rate cycles
// - Workspace counts since entry or repeat
// - Decision returned in same call
`default_nettype none
module bdar_button
  import bdar_pkg::*;
(
  input  wire logic        ref_clk,  // 100 MHz clock
  input  wire logic        rstn,     // Async reset, active low
  input  wire logic [3:0]  addr,     // Register word index
  input  wire logic [31:0] wdata,    // Write data
  input  wire logic        wr,       // Write strobe
  input  wire logic        rd,       // Read strobe
  output logic      [31:0] rdata,    // Read data, cycle after rd
  input  wire logic [15:0] pinIn,    // Button pins, asynchronous
  output logic      [15:0] pinOe,    // Output enable, low = input
  output logic             branch,   // Branch decision of last call
  output logic             done      // Pulse: call completed
);
  bdar_sync_if sif ();

  bdar_pin_sync u_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .pinIn   (pinIn),
    .sif     (sif)
  );

  typedef struct packed {
    logic [6:0]  ctrl;
    logic [7:0]  delay;
    logic [7:0]  rate;
    logic [7:0]  work;
    logic        repeating;
    logic        branch;
    logic        match;
    logic        done;
    logic        doneFlag;
    logic [15:0] pinOe;
    logic [31:0] rdata;
  } bdar_state_s;

  bdar_state_s st;
  bdar_state_s next_st;

  logic [3:0] pinSel;
  logic       sample;
  logic       pressed;
  logic       fire;
  logic       invoke;

  // Pin index, clipped to eight lines in narrow mode
  always_comb begin
    pinSel = st.ctrl[CTRL_PIN_MSB:CTRL_PIN_LSB];
    if (st.ctrl[CTRL_NARROW]) begin
      pinSel = pinSel & NARROW_MAX;
    end
  end

  // One sample of the chosen pin per call
  assign sample  = sif.pinSync[pinSel];
  assign pressed = (sample == st.ctrl[CTRL_PRESSED]);
  assign invoke  = wr && (addr == ADDR_INVOKE);

  // Debounce and repeat engine, one step per call
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    fire         = 1'b0;
    if (wr) begin
      case (addr)
        ADDR_CTRL: begin
          next_st.ctrl = wdata[6:0];
        end
        ADDR_DELAY: begin
          next_st.delay = wdata[7:0];
        end
        ADDR_RATE: begin
          next_st.rate = wdata[7:0];
        end
        ADDR_STATUS: begin
          // Write one clears done flag; no call can share this cycle, since a call needs a write to the invoke address
          if (wdata[STAT_DONE]) begin
            next_st.doneFlag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (invoke) begin
      if (st.delay == DELAY_RAW) begin
        fire              = pressed;
        next_st.work      = WORK_RST;
        next_st.repeating = 1'b0;
      end else if (!pressed) begin
        next_st.work      = WORK_RST;
        next_st.repeating = 1'b0;
      end else if (st.work == WORK_RST && !st.repeating) begin
        fire         = 1'b1;
        next_st.work = 8'h01;
      end else if (st.delay == DELAY_NOREPT) begin
        next_st.work = st.work;
      end else if (!st.repeating) begin
        if (st.work >= st.delay) begin
          fire              = 1'b1;
          next_st.repeating = 1'b1;
          next_st.work      = 8'h01;
        end else begin
          next_st.work = st.work + 8'h01;
        end
      end else begin
        if (st.work >= st.rate) begin
          fire         = 1'b1;
          next_st.work = 8'h01;
        end else begin
          next_st.work = st.work + 8'h01;
        end
      end
      // Target 1 branches on action; target 0 branches when no action
      next_st.branch   = st.ctrl[CTRL_TARGET] ? fire : !fire;
      next_st.match    = pressed;
      next_st.done     = 1'b1;
      next_st.doneFlag = 1'b1;
    end
    // Selected line is held as input: every enable stays low
    next_st.pinOe = '0;
    next_st.rdata = 32'h0000_0000;
    if (rd) begin
      case (addr)
        ADDR_CTRL:   next_st.rdata = {25'h0, st.ctrl};
        ADDR_DELAY:  next_st.rdata = {24'h0, st.delay};
        ADDR_RATE:   next_st.rdata = {24'h0, st.rate};
        ADDR_STATUS: next_st.rdata = {29'h0, st.match, st.doneFlag, st.branch};
        ADDR_WORK:   next_st.rdata = {24'h0, st.work};
        default:     next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register; reset clears everything including workspace
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st       <= '0;
      st.ctrl  <= CTRL_RST;
      st.delay <= DELAY_RST;
      st.rate  <= RATE_RST;
      st.work  <= WORK_RST;
    end else begin
      st <= next_st;
    end
  end

  assign rdata  = st.rdata;
  assign pinOe  = st.pinOe;
  assign branch = st.branch;
  assign done   = st.done;
endmodule
`default_nettype wire

// file: testbench/bdar_button_asserts.sv
/* Port checker for the button engine.
   Bound to bdar_button; sees only its ports. */
`default_nettype none
module bdar_button_asserts
  import bdar_pkg::*;
(
  input wire logic        ref_clk, // Clock
  input wire logic        rstn,    // Reset, active low
  input wire logic [3:0]  addr,    // Word index
  input wire logic        wr,      // Write strobe
  input wire logic        rd,      // Read strobe
  input wire logic [31:0] rdata,   // Read data
  input wire logic [15:0] pinOe,   // Pin enables
  input wire logic        branch,  // Decision
  input wire logic        done     // Call done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // One routine call per invoke write
  wire logic inv = wr && addr == ADDR_INVOKE;
  chk_pins_input: assert property (pinOe == 16'h0000)
    else $error("pin driven");
  chk_call_done: assert property (inv |=> done)
    else $error("no done");
  chk_done_cause: assert property (done |-> $past(inv))
    else $error("stray done");
  chk_branch_hold: assert property (!inv |=> $stable(branch))
    else $error("branch moved");
  chk_rdata_idle: assert property (!rd |=> rdata == 32'h0)
    else $error("rdata not idle");
  chk_unmapped_rd: assert property (rd && addr > ADDR_INVOKE |=> rdata == 32'h0)
    else $error("unmapped nonzero");
  chk_work_byte: assert property (rd && addr == ADDR_WORK |=> rdata[31:8] == 24'h0)
    else $error("work wide");
  chk_status_rsv: assert property (rd && addr == ADDR_STATUS |=> rdata[31:3] == 29'h0)
    else $error("status wide");
  cover property (inv ##1 branch);
  cover property (inv ##2 inv);
  cover property (rd && addr == ADDR_WORK ##1 rdata != 32'h0);
endmodule
bind bdar_button bdar_button_asserts chk_u (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wr(wr),
  .rd(rd), .rdata(rdata), .pinOe(pinOe), .branch(branch), .done(done));
`default_nettype wire

// file: testbench/bdar_switch.sv
/* Switch bank on the button pins.
   Assumes contacts settle once the bench sets them. */
`default_nettype none
module bdar_switch (
  input  wire logic [15:0] press,  // Contacts closed
  input  wire logic        actLow, // Closed pulls low
  output logic      [15:0] pinIn   // Pin levels
);
  timeunit 1ns;
  timeprecision 1ns;
  // Open contacts rest at the wiring's idle level
  assign pinIn = press ^ {16{actLow}};
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
/* Self-checking bench for the button engine.
   Assumes one clock; the switch model drives the pins. */
`default_nettype none
module tb_top
  import bdar_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = '0, rstn = '0, wr = '0, rd = '0, actLow = '0;
  logic [3:0]  addr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [15:0] press = '0, pinIn, pinOe;
  logic        branch, done;
  int          bad_count = 0, compares = 0, cyc = 0;
  // Clock and hang guard
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end
  bdar_switch sw_u (.press(press), .actLow(actLow), .pinIn(pinIn));
  bdar_button dut_u (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pinIn(pinIn), .pinOe(pinOe), .branch(branch), .done(done));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a; rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    chk(rdata, exp);
  endtask
  // Settle time covers the two-flop synchroniser
  task automatic pset(input logic [15:0] p, input logic lo);
    @(posedge ref_clk);
    press <= p; actLow <= lo;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic call(input logic b, input logic [7:0] w);
    wreg(ADDR_INVOKE, '0);
    @(negedge ref_clk);
    chk({31'h0, done}, 32'h1);
    chk({31'h0, branch}, {31'h0, b});
    rreg(ADDR_WORK, {24'h0, w});
  endtask
  task automatic seq(input int n, input logic [7:0] b, input logic [63:0] w);
    for (int i = 0; i < n; i++) begin
      call(b[i], w[8*i+:8]);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence: reset values, repeat timing, special delays, narrow select
  initial begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int a = 0; a < 5; a++) begin
      rreg(a[3:0], '0);
    end
    rreg(4'hf, '0);
    wreg(ADDR_DELAY, 32'h3);
    wreg(ADDR_RATE, 32'h2);
    wreg(ADDR_CTRL, 32'h25);
    pset(16'h0020, 1'b1);
    call(1'b1, 8'h01);
    rreg(ADDR_STATUS, 32'h7);
    seq(5, 8'h14, 64'h0102010302);
    pset(16'h0000, 1'b1);
    call(1'b0, 8'h00);
    pset(16'h0020, 1'b1);
    call(1'b1, 8'h01);
    pset(16'h0000, 1'b1);
    call(1'b0, 8'h00);
    wreg(ADDR_DELAY, 32'hff);
    wreg(ADDR_CTRL, 32'h39);
    pset(16'h0200, 1'b0);
    seq(4, 8'h01, 64'h01010101);
    pset(16'h0000, 1'b0);
    call(1'b0, 8'h00);
    wreg(ADDR_DELAY, 32'h0);
    wreg(ADDR_CTRL, 32'h4d);
    pset(16'h0020, 1'b1);
    call(1'b0, 8'h00);
    pset(16'h2000, 1'b1);
    call(1'b1, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
